// File: shared/odc_consts.svh
// offsets, field positions, reset values and timing of the drive compensation select registers
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH
`define ODC_RISE_OFFSET      12'h050
`define ODC_FALL_OFFSET      12'h054
`define ODC_MUST_LOW_BIT     31
`define ODC_CAL_LSB          16
`define ODC_CAL_MSB          19
`define ODC_SEL_B_LSB        13
`define ODC_SEL_B_MSB        14
`define ODC_OVR_B_LSB        8
`define ODC_OVR_B_MSB        11
`define ODC_SEL_A_LSB        5
`define ODC_SEL_A_MSB        6
`define ODC_OVR_A_LSB        0
`define ODC_OVR_A_MSB        3
`define ODC_CTL_RESET        32'h00000000
`define ODC_STRENGTH_MAX     4'hf
`define ODC_STRENGTH_MIN     4'h0
`define ODC_APB_WAIT_CYCLES  1
`endif

// File: shared/odc_pkg.sv
// types shared by the drive compensation select block
`default_nettype none
package odc_pkg;
    typedef enum logic [1:0] {
        ODC_SEL_CAL,
        ODC_SEL_OVR,
        ODC_SEL_SUM,
        ODC_SEL_DIFF
    } odc_sel_t;

    // writable fields of one bridge inside one control register
    typedef struct packed {
        odc_sel_t   sel;
        logic [3:0] ovr;
    } odc_bridge_cfg_t;

    // both edges' results for one bridge
    typedef struct packed {
        logic [3:0] rise;
        logic [3:0] fall;
    } odc_strength_t;
endpackage
`default_nettype wire

// File: design/odc_select.sv
// drive compensation select register bank with apb slave and per-bridge strength outputs
//
// Functional notes
// - Two control registers exist: 0x50 for rising-edge strength and 0x54 for falling-edge strength.
// - Every strength value is a 4-bit unsigned number from 0h to Fh, larger meaning stronger drive.
// - Bits 19:16 read the calibrator's value, ignore writes, and have no defined reset value.
// - Second bridge selector in bits 14:13: 0 applies the calibrated value, 1 applies its override.
// - Second bridge selector 2 applies calibrated plus override, saturated at Fh.
// - Second bridge selector 3 applies calibrated minus override, clamped at 0h.
// - Bits 11:8 hold the second bridge's read-write override value.
// - Each bridge computes its own result from its own override and selector.
// - First bridge uses the same four-mode selector in bits 6:5 with its override in bits 3:0.
//
// Decided for this implementation: the APB register port.
`include "odc_consts.svh"
`default_nettype none
module odc_select
    import odc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // calibrator results, rising and falling edge
    input  wire logic [3:0]          cal_rise,
    input  wire logic [3:0]          cal_fall,
    // applied strengths, first and second bridge
    output var  odc_strength_t       first_bridge_strength,
    output var  odc_strength_t       second_bridge_strength
);

    // -------------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 12) begin : g_bad_addr
        $error("odc_select: ADDR_W must be 8 to 12");
    end

    // -------------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RISE_ADDR = ADDR_W'(`ODC_RISE_OFFSET);
    localparam logic [ADDR_W-1:0] FALL_ADDR = ADDR_W'(`ODC_FALL_OFFSET);

    logic access;
    logic hit_rise;
    logic hit_fall;
    assign access   = psel && penable;
    assign hit_rise = (paddr == RISE_ADDR);
    assign hit_fall = (paddr == FALL_ADDR);

    // -------------------------------------------------------------------------
    // control registers: rise_cfg_reg rising, fall_cfg_reg falling; [0] first bridge, [1] second
    // -------------------------------------------------------------------------
    odc_bridge_cfg_t rise_cfg_reg [2];
    odc_bridge_cfg_t fall_cfg_reg [2];
    logic            rise_must_low_reg;
    logic            fall_must_low_reg;

    function automatic odc_bridge_cfg_t cfg_from(input logic [31:0] d, input logic second);
        odc_bridge_cfg_t c;
        if (second) begin
            c.sel = odc_sel_t'(d[`ODC_SEL_B_MSB:`ODC_SEL_B_LSB]);
            c.ovr = d[`ODC_OVR_B_MSB:`ODC_OVR_B_LSB];
        end else begin
            c.sel = odc_sel_t'(d[`ODC_SEL_A_MSB:`ODC_SEL_A_LSB]);
            c.ovr = d[`ODC_OVR_A_MSB:`ODC_OVR_A_LSB];
        end
        return c;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cfg_reg[0] <= odc_bridge_cfg_t'(6'h00);
            rise_cfg_reg[1] <= odc_bridge_cfg_t'(6'h00);
            rise_must_low_reg <= 1'b0;
        // writes land only at the completing edge, so the wait state never commits early
        end else if (access && pready && pwrite && hit_rise) begin
            rise_cfg_reg[0] <= cfg_from(pwdata, 1'b0);
            rise_cfg_reg[1] <= cfg_from(pwdata, 1'b1);
            // stored only so software reads back what it wrote; never steers anything
            rise_must_low_reg <= pwdata[`ODC_MUST_LOW_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_cfg_reg[0] <= odc_bridge_cfg_t'(6'h00);
            fall_cfg_reg[1] <= odc_bridge_cfg_t'(6'h00);
            fall_must_low_reg <= 1'b0;
        // same completing-edge rule as the rising register
        end else if (access && pready && pwrite && hit_fall) begin
            fall_cfg_reg[0] <= cfg_from(pwdata, 1'b0);
            fall_cfg_reg[1] <= cfg_from(pwdata, 1'b1);
            fall_must_low_reg <= pwdata[`ODC_MUST_LOW_BIT];
        end
    end

    // -------------------------------------------------------------------------
    // strength arithmetic
    // -------------------------------------------------------------------------
    // five-bit sum and difference so carry and borrow expose the saturate and clamp cases
    function automatic logic [3:0] apply_sel(input logic [3:0] cal, input odc_bridge_cfg_t c);
        logic [4:0] sum;
        logic [4:0] dif;
        sum = {1'b0, cal} + {1'b0, c.ovr};
        dif = {1'b0, cal} - {1'b0, c.ovr};
        case (c.sel)
            ODC_SEL_CAL:  apply_sel = cal;
            ODC_SEL_OVR:  apply_sel = c.ovr;
            ODC_SEL_SUM:  apply_sel = sum[4] ? `ODC_STRENGTH_MAX : sum[3:0];
            ODC_SEL_DIFF: apply_sel = dif[4] ? `ODC_STRENGTH_MIN : dif[3:0];
            default:      apply_sel = cal;
        endcase
    endfunction

    logic [3:0] rise_next [2];
    logic [3:0] fall_next [2];

    for (genvar b = 0; b < 2; b++) begin : g_bridge
        assign rise_next[b] = apply_sel(cal_rise, rise_cfg_reg[b]);
        assign fall_next[b] = apply_sel(cal_fall, fall_cfg_reg[b]);
    end

    // registered so that the outputs come straight from flip-flops; one cycle behind inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_bridge_strength  <= '0;
            second_bridge_strength <= '0;
        end else begin
            first_bridge_strength  <= '{rise: rise_next[0], fall: fall_next[0]};
            second_bridge_strength <= '{rise: rise_next[1], fall: fall_next[1]};
        end
    end

    // -------------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------------
    // bit 31 reads back what was written; software must keep it low
    function automatic logic [31:0] pack_reg(input logic ml, input logic [3:0] cal,
                                             input odc_bridge_cfg_t a, input odc_bridge_cfg_t b);
        logic [31:0] d;
        d = `ODC_CTL_RESET;
        d[`ODC_MUST_LOW_BIT]              = ml;
        d[`ODC_CAL_MSB:`ODC_CAL_LSB]      = cal;
        d[`ODC_SEL_B_MSB:`ODC_SEL_B_LSB]  = b.sel;
        d[`ODC_OVR_B_MSB:`ODC_OVR_B_LSB]  = b.ovr;
        d[`ODC_SEL_A_MSB:`ODC_SEL_A_LSB]  = a.sel;
        d[`ODC_OVR_A_MSB:`ODC_OVR_A_LSB]  = a.ovr;
        return d;
    endfunction

    logic [31:0] prdata_next;
    always_comb begin
        prdata_next = '0;
        if (hit_rise) begin
            prdata_next = pack_reg(rise_must_low_reg, cal_rise, rise_cfg_reg[0], rise_cfg_reg[1]);
        end else if (hit_fall) begin
            prdata_next = pack_reg(fall_must_low_reg, cal_fall, fall_cfg_reg[0], fall_cfg_reg[1]);
        end
    end

    // one wait state: setup, access (pready low), access (pready high)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : prdata_next;
            pslverr <= !(hit_rise || hit_fall);
        end else begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    // every property samples on pclk and is off while presetn is low
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SUM_SATURATES: assert property (
        rise_cfg_reg[1].sel == ODC_SEL_SUM && ({1'b0, cal_rise} + {1'b0, rise_cfg_reg[1].ovr}) > 5'h0f
        |=> second_bridge_strength.rise == 4'hf)
        else $error("sum mode did not saturate");
    AST_SUM_VALUE: assert property (
        fall_cfg_reg[0].sel == ODC_SEL_SUM && ({1'b0, cal_fall} + {1'b0, fall_cfg_reg[0].ovr}) <= 5'h0f
        |=> first_bridge_strength.fall == $past(cal_fall) + $past(fall_cfg_reg[0].ovr))
        else $error("sum mode value wrong");
    AST_DIFF_CLAMPS: assert property (
        rise_cfg_reg[0].sel == ODC_SEL_DIFF && cal_rise < rise_cfg_reg[0].ovr
        |=> first_bridge_strength.rise == 4'h0)
        else $error("difference mode did not clamp");
    AST_DIFF_VALUE: assert property (
        fall_cfg_reg[1].sel == ODC_SEL_DIFF && cal_fall >= fall_cfg_reg[1].ovr
        |=> second_bridge_strength.fall == $past(cal_fall) - $past(fall_cfg_reg[1].ovr))
        else $error("difference mode value wrong");
    AST_CAL_PASS: assert property (
        rise_cfg_reg[1].sel == ODC_SEL_CAL |=> second_bridge_strength.rise == $past(cal_rise))
        else $error("calibrated mode wrong");
    AST_OVR_PASS: assert property (
        fall_cfg_reg[0].sel == ODC_SEL_OVR |=> first_bridge_strength.fall == $past(fall_cfg_reg[0].ovr))
        else $error("override mode wrong");
    AST_WRITE_LANDS: assert property (
        access && pready && pwrite && hit_rise
        |=> rise_cfg_reg[1].ovr == $past(pwdata[`ODC_OVR_B_MSB:`ODC_OVR_B_LSB]))
        else $error("override write lost");
    AST_READ_CAL: assert property (
        access && !pready && !pwrite && hit_fall
        |=> pready && prdata[`ODC_CAL_MSB:`ODC_CAL_LSB] == $past(cal_fall))
        else $error("calibrated readback wrong");
    AST_ONE_WAIT: assert property (
        psel && !penable ##1 access |-> !pready ##1 pready)
        else $error("apb answer timing wrong");

    // bus answer shape
    AST_UNMAPPED_ERR: assert property (
        access && !pready && !(hit_rise || hit_fall) |=> pready && pslverr)
        else $error("unmapped access without error");
    AST_MAPPED_OK: assert property (
        access && !pready && (hit_rise || hit_fall) |=> pready && !pslverr)
        else $error("mapped access flagged as error");
    AST_READY_PULSE: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_WRITE_READS_ZERO: assert property (
        access && !pready && pwrite |=> prdata == 32'h00000000)
        else $error("read data not zero on a write");
    AST_RESERVED_ZERO: assert property (
        pready |-> prdata[30:20] == 11'h000 && !prdata[15] && !prdata[12] && !prdata[7] && !prdata[4])
        else $error("reserved bits read nonzero");

    // register contents
    AST_NO_EARLY_WRITE: assert property (
        access && !pready
        |=> rise_cfg_reg[1] == $past(rise_cfg_reg[1]) && fall_cfg_reg[1] == $past(fall_cfg_reg[1]))
        else $error("config changed before the completing edge");
    AST_SEL_WRITE: assert property (
        access && pready && pwrite && hit_rise
        |=> rise_cfg_reg[1].sel == $past(pwdata[`ODC_SEL_B_MSB:`ODC_SEL_B_LSB]))
        else $error("selector write lost");
    AST_FIRST_OVR_WRITE: assert property (
        access && pready && pwrite && hit_fall
        |=> fall_cfg_reg[0].ovr == $past(pwdata[`ODC_OVR_A_MSB:`ODC_OVR_A_LSB]))
        else $error("first bridge override write lost");
    AST_READ_CAL_RISE: assert property (
        access && !pready && !pwrite && hit_rise
        |=> prdata[`ODC_CAL_MSB:`ODC_CAL_LSB] == $past(cal_rise))
        else $error("rising calibrated readback wrong");
    AST_OVR_READBACK: assert property (
        access && !pready && !pwrite && hit_rise
        |=> prdata[`ODC_OVR_B_MSB:`ODC_OVR_B_LSB] == $past(rise_cfg_reg[1].ovr))
        else $error("override readback wrong");

    // arithmetic per bridge and edge
    AST_FIRST_SAT: assert property (
        rise_cfg_reg[0].sel == ODC_SEL_SUM && ({1'b0, cal_rise} + {1'b0, rise_cfg_reg[0].ovr}) > 5'h0f
        |=> first_bridge_strength.rise == 4'hf)
        else $error("first bridge sum did not saturate");
    AST_FIRST_DIFF_VALUE: assert property (
        rise_cfg_reg[0].sel == ODC_SEL_DIFF && cal_rise >= rise_cfg_reg[0].ovr
        |=> first_bridge_strength.rise == $past(cal_rise) - $past(rise_cfg_reg[0].ovr))
        else $error("first bridge difference wrong");
    AST_FIRST_CAL: assert property (
        fall_cfg_reg[0].sel == ODC_SEL_CAL |=> first_bridge_strength.fall == $past(cal_fall))
        else $error("first bridge calibrated mode wrong");
    AST_SECOND_OVR: assert property (
        rise_cfg_reg[1].sel == ODC_SEL_OVR |=> second_bridge_strength.rise == $past(rise_cfg_reg[1].ovr))
        else $error("second bridge override mode wrong");
    AST_SECOND_SUM_VALUE: assert property (
        fall_cfg_reg[1].sel == ODC_SEL_SUM && ({1'b0, cal_fall} + {1'b0, fall_cfg_reg[1].ovr}) <= 5'h0f
        |=> second_bridge_strength.fall == $past(cal_fall) + $past(fall_cfg_reg[1].ovr))
        else $error("second bridge sum wrong");
    AST_SECOND_CLAMP: assert property (
        fall_cfg_reg[1].sel == ODC_SEL_DIFF && cal_fall < fall_cfg_reg[1].ovr
        |=> second_bridge_strength.fall == 4'h0)
        else $error("second bridge difference did not clamp");
    AST_SECOND_DIFF_VALUE: assert property (
        rise_cfg_reg[1].sel == ODC_SEL_DIFF && cal_rise >= rise_cfg_reg[1].ovr
        |=> second_bridge_strength.rise == $past(cal_rise) - $past(rise_cfg_reg[1].ovr))
        else $error("second bridge rising difference wrong");
    // a change to the second bridge's falling config must leave the first bridge's falling output alone
    AST_BRIDGES_APART: assert property (
        $stable(cal_fall) && $stable(fall_cfg_reg[0]) && !$stable(fall_cfg_reg[1])
        |=> $stable(first_bridge_strength.fall))
        else $error("first bridge output moved with second bridge config");

    COV_SUM_SAT: cover property (second_bridge_strength.rise == 4'hf && rise_cfg_reg[1].sel == ODC_SEL_SUM);
    COV_DIFF_CLAMP: cover property (first_bridge_strength.rise == 4'h0 && rise_cfg_reg[0].sel == ODC_SEL_DIFF);
    COV_ERR: cover property (pready && pslverr);
    COV_MIXED: cover property (rise_cfg_reg[0].sel != rise_cfg_reg[1].sel);
    COV_BRIDGES_APART: cover property ($stable(fall_cfg_reg[0]) && !$stable(fall_cfg_reg[1]));

endmodule
`default_nettype wire

// File: tb/odc_select_bench.sv
// self-checking testbench for the drive compensation select register bank
`include "odc_consts.svh"
`default_nettype none
module odc_select_bench
    import odc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic [3:0]    cal_rise, cal_fall;
    logic          er;
    odc_strength_t first_bridge_strength, second_bridge_strength;
    int            err_total, total_checks;

    odc_select u_odc_select (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cal_rise(cal_rise), .cal_fall(cal_fall), .first_bridge_strength(first_bridge_strength),
        .second_bridge_strength(second_bridge_strength));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; waits for pready as long as it takes, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("apb_wait_edges", 32'(`ODC_APB_WAIT_CYCLES + 1), 32'(n));
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    function automatic logic [31:0] word(input logic [1:0] sb, input logic [3:0] ob, input logic [1:0] sa,
                                         input logic [3:0] oa);
        return {17'h0, sb, 1'b0, ob, 1'b0, sa, 1'b0, oa};
    endfunction
    function automatic logic [3:0] pick(input logic [1:0] s, input logic [3:0] c, input logic [3:0] o);
        case (s)
            2'h0: return c;
            2'h1: return o;
            2'h2: return ({1'b0, c} + {1'b0, o} > 5'h0f) ? 4'hf : c + o;
            default: return (c < o) ? 4'h0 : c - o;
        endcase
    endfunction
    // outputs lag the stored config by one clock, so allow a few edges before looking
    task automatic chk_out(input logic [3:0] fr, input logic [3:0] ff, input logic [3:0] sr, input logic [3:0] sf);
        repeat (3) @(posedge pclk);
        chk("first_bridge_strength", {24'h0, fr, ff}, {24'h0, first_bridge_strength});
        chk("second_bridge_strength", {24'h0, sr, sf}, {24'h0, second_bridge_strength});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk_out(cal_rise, cal_fall, cal_rise, cal_fall);
        apb(1'b0, `ODC_RISE_OFFSET, 32'h0);
        chk("rise_reg", {12'h0, cal_rise, 16'h0}, rd);
        chk("rd_err_mapped", 32'h0, {31'h0, er});
        apb(1'b0, `ODC_FALL_OFFSET, 32'h0);
        chk("fall_reg", {12'h0, cal_fall, 16'h0}, rd);
        $display("test reset done");
    endtask
    task automatic t_fields();
        apb(1'b1, `ODC_FALL_OFFSET, 32'h7fffffff);
        apb(1'b0, `ODC_FALL_OFFSET, 32'h0);
        chk("fall_fields", {12'h000, cal_fall, 16'h6f6f}, rd);
        apb(1'b1, `ODC_FALL_OFFSET, 32'h0);
        apb(1'b0, `ODC_FALL_OFFSET, 32'h0);
        chk("fall_cleared", {12'h0, cal_fall, 16'h0}, rd);
        $display("test fields done");
    endtask
    task automatic t_modes();
        logic [1:0] sb, sa, fb, fa;
        cal_rise <= 4'hc;
        cal_fall <= 4'h3;
        for (int m = 0; m < 4; m++) begin
            sb = 2'(m); sa = 2'(3 - m); fb = 2'(m + 1); fa = 2'(m + 2);
            apb(1'b1, `ODC_RISE_OFFSET, word(sb, 4'h7, sa, 4'h3));
            apb(1'b1, `ODC_FALL_OFFSET, word(fb, 4'h5, fa, 4'h1));
            apb(1'b0, `ODC_RISE_OFFSET, 32'h0);
            chk("rise_readback", word(sb, 4'h7, sa, 4'h3) | 32'h000c0000, rd);
            chk_out(pick(sa, 4'hc, 4'h3), pick(fa, 4'h3, 4'h1), pick(sb, 4'hc, 4'h7), pick(fb, 4'h3, 4'h5));
        end
        $display("test modes done");
    endtask
    task automatic t_unmapped();
        apb(1'b1, 12'h058, 32'h7fffffff);
        chk("wr_err", 32'h1, {31'h0, er});
        apb(1'b0, 12'h058, 32'h0);
        chk("rd_unmapped", 32'h0, rd);
        chk("rd_err", 32'h1, {31'h0, er});
        $display("test unmapped done");
    endtask
    task automatic t_cal_follow();
        apb(1'b1, `ODC_RISE_OFFSET, word(2'h3, 4'h2, 2'h2, 4'h2));
        // first bridge falling config is written again with what the modes test left: override mode, override 1
        apb(1'b1, `ODC_FALL_OFFSET, word(2'h3, 4'h2, 2'h1, 4'h1));
        cal_rise <= 4'h1;
        chk_out(4'h3, 4'h1, 4'h0, 4'h1);
        cal_rise <= 4'he;
        cal_fall <= 4'h9;
        chk_out(4'hf, 4'h1, 4'hc, 4'h7);
        apb(1'b1, `ODC_RISE_OFFSET, word(2'h1, 4'h5, 2'h3, 4'h4));
        cal_rise <= 4'h2;
        chk_out(4'h0, 4'h1, 4'h5, 4'h7);
        $display("test cal follow done");
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        err_total = 0; total_checks = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; cal_rise = 4'ha; cal_fall = 4'h5;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_modes();
        t_unmapped();
        t_cal_follow();
        end_of_test();
    end
    initial begin
        #40000;
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
